/* hdl/eifd_pkg.sv */
package eifd_pkg;

    // ------------------------------------------------------------
    // event input functions
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        EIFD_FN_NONE = 4'h0,
        EIFD_FN_RUN_STOP = 4'h1,
        EIFD_FN_HAND_OPERATION_SELECT = 4'h2,
        EIFD_FN_PROGRAM_LAUNCH = 4'h3,
        EIFD_FN_DIRECTION_INVERT = 4'h4,
        EIFD_FN_REMOTE_SETPOINT_SELECT = 4'h5,
        EIFD_FN_FULL_DEVIATION_TUNE = 4'h6,
        EIFD_FN_REDUCED_DEVIATION_TUNE = 4'h7,
        EIFD_FN_SETTING_LOCK = 4'h8,
        EIFD_FN_COMM_WRITE_GATE = 4'h9,
        EIFD_FN_ALARM_HOLD_CLEAR = 4'hA
    } eifd_func_t;

    localparam int unsigned EIFD_FN_COUNT = 11;
    localparam int unsigned EIFD_INPUTS = 4;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] EIFD_ADDR_FUNCTION = 8'h00;
    localparam logic [7:0] EIFD_ADDR_CONFIG = 8'h04;
    localparam logic [7:0] EIFD_ADDR_INPUTS = 8'h08;
    localparam logic [7:0] EIFD_ADDR_COMMANDS = 8'h0C;
    localparam logic [7:0] EIFD_ADDR_REJECT = 8'h10;

    // config field positions
    localparam int unsigned EIFD_CFG_BANK_LSB = 0;
    localparam int unsigned EIFD_CFG_PATTERN_ON = 4;
    localparam int unsigned EIFD_CFG_HEAT_COOL = 5;
    localparam int unsigned EIFD_CFG_REVERSE = 6;
    localparam int unsigned EIFD_CFG_WORK_BIT = 7;
    localparam int unsigned EIFD_CFG_LOGIC_OP = 8;

    localparam logic [15:0] EIFD_FUNCTION_RESET = 16'h0000;
    localparam logic [8:0] EIFD_CONFIG_RESET = 9'h001;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned EIFD_CLK_HZ = 25000000;
    localparam int unsigned EIFD_DETECT_MS = 50;
    localparam int unsigned EIFD_LOGIC_MS = 250;
    localparam int unsigned EIFD_DETECT_CYCLES = (EIFD_CLK_HZ / 1000) * EIFD_DETECT_MS;
    localparam int unsigned EIFD_LOGIC_CYCLES = (EIFD_CLK_HZ / 1000) * EIFD_LOGIC_MS;

    // ------------------------------------------------------------
    // command bundle to controller
    // ------------------------------------------------------------
    typedef struct packed {
        logic control_stop;
        logic stop_indicator;
        logic hand_operation_select;
        logic hand_indicator;
        logic program_run;
        logic program_reset;
        logic program_end_clear;
        logic direction_reverse;
        logic remote_setpoint_select;
        logic remote_indicator;
        logic full_deviation_tune;
        logic reduced_deviation_tune;
        logic setting_lock;
        logic comm_write_enable;
        logic alarm_hold_clear;
    } eifd_cmd_t;

endpackage

/* hdl/eifd_event_input_function_decoder.sv */
// Operation
// - each assignment picks one of eleven actions
// - program launch accepted, inert when pattern off
// - remote setpoint choice only on remote variants
// - reduced tune ignored under heating/cooling
// - comm gate needs comms, no work bit
// - non-none action used by one input only
// - level changes need 50 ms persistence
// - logic-operation feed needs 250 ms persistence
// - input on stops control, off runs
// - stop indicator lit while stopped
// - input on selects manual, lights indicator
// - on starts program, off resets and stops
// - program reset clears program-end output
// - input on inverts configured direction
// - input on selects remote setpoint, indicator
// - full-deviation tune follows input level
// - reduced-deviation tune follows input level
// - input on locks setting changes
// - comm gate only on inputs three, four
// - input on allows communications writes
// - input on clears all alarm latches
// - inputs three/four act as one/two
// - bank-selection inputs take no function
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
module eifd_event_input_function_decoder #(
    parameter int unsigned DETECT_CYCLES = eifd_pkg::EIFD_DETECT_CYCLES,
    parameter int unsigned LOGIC_CYCLES = eifd_pkg::EIFD_LOGIC_CYCLES,
    parameter bit HAS_REMOTE_SP = 1'b1,
    parameter bit HAS_COMMS = 1'b1,
    parameter bit INPUTS_THREE_FOUR = 1'b0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] event_in,
    input wire logic program_end_active,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output eifd_pkg::eifd_cmd_t cmd,
    output logic [3:0] logic_op_state
);

    localparam int unsigned CW = $clog2(LOGIC_CYCLES + 1);

    if (DETECT_CYCLES < 1 || LOGIC_CYCLES < DETECT_CYCLES) begin : g_bad_filter
        $error("eifd: filter lengths out of range");
    end

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic fn_allowed(input logic [3:0] f, input int unsigned idx, input logic work_bit);
        logic ok;
        ok = (f < 4'(eifd_pkg::EIFD_FN_COUNT));
        if (f == eifd_pkg::EIFD_FN_REMOTE_SETPOINT_SELECT && !HAS_REMOTE_SP) begin
            ok = 1'b0;
        end
        if (f == eifd_pkg::EIFD_FN_COMM_WRITE_GATE) begin
            if (!HAS_COMMS || work_bit || idx < 2) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    function automatic logic active_of(input logic [15:0] fr, input logic [3:0] used, input logic [3:0] lvl,
                                       input eifd_pkg::eifd_func_t f);
        logic a;
        a = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (used[i] && fr[4*i +: 4] == f) begin
                a = a | lvl[i];
            end
        end
        return a;
    endfunction

    function automatic logic assigned_of(input logic [15:0] fr, input logic [3:0] used,
                                         input eifd_pkg::eifd_func_t f);
        logic a;
        a = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (used[i] && fr[4*i +: 4] == f) begin
                a = 1'b1;
            end
        end
        return a;
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0] function_reg;
    logic [8:0] config_reg;
    logic [3:0] reject_reg;
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [3:0] level_reg;
    logic [3:0] logic_reg;
    logic [CW-1:0] det_cnt_reg [4];
    logic [CW-1:0] log_cnt_reg [4];

    // ------------------------------------------------------------
    // synchroniser and persistence filters
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end else begin
            sync1_reg <= event_in;
            sync2_reg <= sync1_reg;
        end
    end

    for (genvar g = 0; g < 4; g++) begin : g_filt
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                det_cnt_reg[g] <= '0;
                level_reg[g] <= 1'b0;
            end else if (sync2_reg[g] == level_reg[g]) begin
                det_cnt_reg[g] <= '0;
            end else if (det_cnt_reg[g] == CW'(DETECT_CYCLES - 1)) begin
                det_cnt_reg[g] <= '0;
                level_reg[g] <= sync2_reg[g];
            end else begin
                det_cnt_reg[g] <= det_cnt_reg[g] + CW'(1);
            end
        end
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                log_cnt_reg[g] <= '0;
                logic_reg[g] <= 1'b0;
            end else if (sync2_reg[g] == logic_reg[g]) begin
                log_cnt_reg[g] <= '0;
            end else if (log_cnt_reg[g] == CW'(LOGIC_CYCLES - 1)) begin
                log_cnt_reg[g] <= '0;
                logic_reg[g] <= sync2_reg[g];
            end else begin
                log_cnt_reg[g] <= log_cnt_reg[g] + CW'(1);
            end
        end
    end
    assign logic_op_state = logic_reg;

    // ------------------------------------------------------------
    // input usage after bank selection
    // ------------------------------------------------------------
    wire [1:0] bank_count_used = config_reg[eifd_pkg::EIFD_CFG_BANK_LSB +: 2];
    wire [3:0] bank_mask = (bank_count_used == 2'd0) ? 4'h0 :
                           (bank_count_used == 2'd1) ? 4'h1 :
                           (bank_count_used == 2'd2) ? 4'h3 : 4'h7;
    // three/four variants remap their pins onto slots one and two
    wire [3:0] pin_levels = INPUTS_THREE_FOUR ? {2'b00, level_reg[3:2]} : level_reg;
    wire [3:0] present = INPUTS_THREE_FOUR ? 4'h3 : 4'hF;
    wire [3:0] used = present & ~bank_mask;

    // ------------------------------------------------------------
    // write acceptance of function assignments
    // ------------------------------------------------------------
    logic [15:0] fn_candidate;
    logic [3:0] fn_reject;
    always_comb begin
        fn_candidate = s_axi_wdata[15:0];
        fn_reject = 4'h0;
        for (int i = 0; i < 4; i++) begin
            if (!fn_allowed(fn_candidate[4*i +: 4], INPUTS_THREE_FOUR ? i + 2 : i,
                            config_reg[eifd_pkg::EIFD_CFG_WORK_BIT])) begin
                fn_reject[i] = 1'b1;
            end
            for (int j = 0; j < i; j++) begin
                if (fn_candidate[4*i +: 4] != 4'h0 && fn_candidate[4*i +: 4] == fn_candidate[4*j +: 4]) begin
                    fn_reject[i] = 1'b1;
                end
            end
        end
    end
    // rejected slots keep their old value; and choices accepted
    logic [15:0] fn_merged;
    always_comb begin
        fn_merged = function_reg;
        for (int i = 0; i < 4; i++) begin
            if (!fn_reject[i] && s_axi_wstrb[i/2]) begin
                fn_merged[4*i +: 4] = fn_candidate[4*i +: 4];
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    wire wr_fn = do_write && awaddr_reg == eifd_pkg::EIFD_ADDR_FUNCTION;
    wire wr_cfg = do_write && awaddr_reg == eifd_pkg::EIFD_ADDR_CONFIG;
    wire wr_hit = wr_fn || wr_cfg;

    logic [15:0] fn_write_val;
    logic [3:0] rej_write_val;
    always_comb begin
        fn_write_val = function_reg;
        rej_write_val = 4'h0;
        for (int i = 0; i < 4; i++) begin
            if (wstrb_reg[i/2]) begin
                if (fn_allowed(wdata_reg[4*i +: 4], INPUTS_THREE_FOUR ? i + 2 : i,
                               config_reg[eifd_pkg::EIFD_CFG_WORK_BIT])) begin
                    fn_write_val[4*i +: 4] = wdata_reg[4*i +: 4];
                end else begin
                    rej_write_val[i] = 1'b1;
                end
            end
        end
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 4; j++) begin
                if (i != j && fn_write_val[4*i +: 4] != 4'h0 && fn_write_val[4*i +: 4] == fn_write_val[4*j +: 4]
                    && wstrb_reg[i/2] && !rej_write_val[i] && (j < i || !wstrb_reg[j/2])) begin
                    rej_write_val[i] = 1'b1;
                end
            end
        end
        for (int i = 0; i < 4; i++) begin
            if (rej_write_val[i]) begin
                fn_write_val[4*i +: 4] = function_reg[4*i +: 4];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            if (aw_take) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr[7:0];
            end
            if (w_take) begin
                w_hold_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            function_reg <= eifd_pkg::EIFD_FUNCTION_RESET;
            config_reg <= eifd_pkg::EIFD_CONFIG_RESET;
            reject_reg <= 4'h0;
        end else begin
            if (wr_fn) begin
                function_reg <= fn_write_val;
                reject_reg <= rej_write_val;
            end
            if (wr_cfg && wstrb_reg[0]) begin
                config_reg[7:0] <= wdata_reg[7:0];
            end
            if (wr_cfg && wstrb_reg[1]) begin
                config_reg[8] <= wdata_reg[8];
            end
        end
    end

    // read channel
    eifd_pkg::eifd_cmd_t cmd_next;
    wire [7:0] ra = s_axi_araddr[7:0];
    wire [31:0] rd_val = (ra == eifd_pkg::EIFD_ADDR_FUNCTION) ? {16'h0, function_reg} :
                         (ra == eifd_pkg::EIFD_ADDR_CONFIG) ? {23'h0, config_reg} :
                         (ra == eifd_pkg::EIFD_ADDR_INPUTS) ? {24'h0, logic_reg, level_reg} :
                         (ra == eifd_pkg::EIFD_ADDR_COMMANDS) ? {17'h0, cmd} :
                         (ra == eifd_pkg::EIFD_ADDR_REJECT) ? {28'h0, reject_reg} : 32'h0;
    wire rd_hit = ra == eifd_pkg::EIFD_ADDR_FUNCTION || ra == eifd_pkg::EIFD_ADDR_CONFIG ||
                  ra == eifd_pkg::EIFD_ADDR_INPUTS || ra == eifd_pkg::EIFD_ADDR_COMMANDS ||
                  ra == eifd_pkg::EIFD_ADDR_REJECT;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    wire pattern_on = config_reg[eifd_pkg::EIFD_CFG_PATTERN_ON];
    wire heat_cool = config_reg[eifd_pkg::EIFD_CFG_HEAT_COOL];
    wire reverse_cfg = config_reg[eifd_pkg::EIFD_CFG_REVERSE];
    wire launch_assigned = assigned_of(function_reg, used, eifd_pkg::EIFD_FN_PROGRAM_LAUNCH) && pattern_on;
    wire launch_on = active_of(function_reg, used, pin_levels, eifd_pkg::EIFD_FN_PROGRAM_LAUNCH);
    wire launch_reset = launch_assigned && !launch_on;
    wire stop_in = active_of(function_reg, used, pin_levels, eifd_pkg::EIFD_FN_RUN_STOP);
    wire hand_in = active_of(function_reg, used, pin_levels, eifd_pkg::EIFD_FN_HAND_OPERATION_SELECT);
    wire remote_in = active_of(function_reg, used, pin_levels, eifd_pkg::EIFD_FN_REMOTE_SETPOINT_SELECT);

    always_comb begin
        cmd_next = '0;
        cmd_next.control_stop = stop_in || launch_reset;
        cmd_next.stop_indicator = stop_in || launch_reset;
        cmd_next.hand_operation_select = hand_in;
        cmd_next.hand_indicator = hand_in;
        cmd_next.program_run = launch_assigned && launch_on;
        cmd_next.program_reset = launch_reset;
        cmd_next.program_end_clear = launch_reset && program_end_active;
        cmd_next.direction_reverse = reverse_cfg ^
            active_of(function_reg, used, pin_levels, eifd_pkg::EIFD_FN_DIRECTION_INVERT);
        cmd_next.remote_setpoint_select = remote_in && HAS_REMOTE_SP;
        cmd_next.remote_indicator = remote_in && HAS_REMOTE_SP;
        cmd_next.full_deviation_tune =
            active_of(function_reg, used, pin_levels, eifd_pkg::EIFD_FN_FULL_DEVIATION_TUNE);
        cmd_next.reduced_deviation_tune = !heat_cool &&
            active_of(function_reg, used, pin_levels, eifd_pkg::EIFD_FN_REDUCED_DEVIATION_TUNE);
        cmd_next.setting_lock =
            active_of(function_reg, used, pin_levels, eifd_pkg::EIFD_FN_SETTING_LOCK);
        cmd_next.comm_write_enable = HAS_COMMS && !config_reg[eifd_pkg::EIFD_CFG_WORK_BIT] &&
            active_of(function_reg, used, pin_levels, eifd_pkg::EIFD_FN_COMM_WRITE_GATE);
        cmd_next.alarm_hold_clear =
            active_of(function_reg, used, pin_levels, eifd_pkg::EIFD_FN_ALARM_HOLD_CLEAR);
    end

    eifd_pkg::eifd_cmd_t cmd_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_reg <= '0;
        end else begin
            cmd_reg <= cmd_next;
        end
    end
    assign cmd = cmd_reg;

endmodule

/* testbench/eifd_properties.sv */
module eifd_properties #(
    parameter int unsigned DETECT_CYCLES = 5,
    parameter int unsigned LOGIC_CYCLES = 20
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] event_in,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire eifd_pkg::eifd_cmd_t cmd,
    input wire logic [3:0] logic_op_state
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // stability count of input one after two flops
    // ------------------------------------------------------------
    logic [1:0] sync_reg;
    logic [7:0] stab_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_reg <= 2'h0;
            stab_reg <= 8'h00;
        end else begin
            sync_reg <= {sync_reg[0], event_in[0]};
            stab_reg <= (sync_reg[1] != sync_reg[0]) ? 8'h00 : ((stab_reg == 8'hFF) ? stab_reg : stab_reg + 8'h01);
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence wr_answer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    AST_WR_RESP: assert property (wr_taken |=> wr_answer)
        else $error("write response not two edges after take");
    AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response not one edge after take");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    AST_STOP_IND: assert property (cmd.control_stop == cmd.stop_indicator)
        else $error("stop indicator differs from stop state");
    AST_HAND_IND: assert property (cmd.hand_operation_select == cmd.hand_indicator)
        else $error("manual indicator differs from manual state");
    AST_REMOTE_IND: assert property (cmd.remote_setpoint_select == cmd.remote_indicator)
        else $error("remote indicator differs from remote state");
    AST_PROG_RESET: assert property (cmd.program_reset |-> cmd.control_stop && !cmd.program_run)
        else $error("program reset without stop");
    AST_LOGIC_FILT: assert property (!$stable(logic_op_state[0]) |-> $past(stab_reg) >= LOGIC_CYCLES - 2)
        else $error("logic level changed before qualification time");
endmodule

/* testbench/eifd_contact_model.sv */
module eifd_contact_model (
    input wire logic aclk,
    output logic [3:0] event_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial event_in = 4'h0;
    task drive(input logic [3:0] v);
        @(posedge aclk);
        event_in <= v;
    endtask
    // short contact bounce of n cycles
    task bounce(input logic [3:0] m, input int n);
        @(posedge aclk);
        event_in <= event_in ^ m;
        repeat (n) @(posedge aclk);
        event_in <= event_in ^ m;
    endtask
endmodule

/* testbench/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned DET = 5;
    localparam int unsigned LOG = 20;
    localparam int unsigned LAT = DET + 4;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic end_act = 1'b1;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, d;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic [3:0] event_in, lop;
    eifd_pkg::eifd_cmd_t cmd;
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;
    always #20 aclk = ~aclk;
    eifd_contact_model eifd_contact_model_i (.aclk(aclk), .event_in(event_in));
    eifd_event_input_function_decoder #(.DETECT_CYCLES(DET), .LOGIC_CYCLES(LOG)) eifd_event_input_function_decoder_i (
        .aclk(aclk), .aresetn(aresetn), .event_in(event_in), .program_end_active(end_act),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .cmd(cmd), .logic_op_state(lop));
    task report_and_stop;
        $display("mismatches %0d of %0d checks", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            report_and_stop();
        end
    end
    task wr(input logic [7:0] a, input logic [31:0] v);
        logic aw_ok, w_ok, b_ok;
        @(posedge aclk);
        awaddr <= {24'h0, a};
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw_ok = awvalid && awready;
            w_ok = wvalid && wready;
            b_ok = bvalid;
            @(posedge aclk);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end while (!b_ok);
        bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
        logic ar_ok, r_ok;
        @(posedge aclk);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            ar_ok = arvalid && arready;
            r_ok = rvalid;
            v = rdata;
            e = rresp;
            @(posedge aclk);
            if (ar_ok) arvalid <= 1'b0;
        end while (!r_ok);
        rready <= 1'b0;
    endtask
    task run(input logic [7:0] cfg, input logic [15:0] fn, input logic [3:0] ev, input logic [14:0] exp);
        wr(eifd_pkg::EIFD_ADDR_CONFIG, {24'h0, cfg});
        wr(eifd_pkg::EIFD_ADDR_FUNCTION, {16'h0, fn});
        eifd_contact_model_i.drive(ev);
        repeat (LAT) @(posedge aclk);
        check({17'h0, cmd}, {17'h0, exp});
    endtask
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(eifd_pkg::EIFD_ADDR_FUNCTION, d, r);
        check(d, 32'h0000_0000);
        rd(eifd_pkg::EIFD_ADDR_CONFIG, d, r);
        check(d, 32'h0000_0001);
        rd(8'h20, d, r);
        check({d[29:0], r}, 32'h0000_0002);
        run(8'h10, 16'h0001, 4'h1, 15'h6000);
        run(8'h10, 16'h0001, 4'h0, 15'h0000);
        run(8'h10, 16'h0002, 4'h1, 15'h1800);
        run(8'h10, 16'h0002, 4'h0, 15'h0000);
        run(8'h10, 16'h0003, 4'h1, 15'h0400);
        run(8'h10, 16'h0003, 4'h0, 15'h6300);
        end_act <= 1'b0;
        run(8'h10, 16'h0003, 4'h0, 15'h6200);
        run(8'h00, 16'h0003, 4'h1, 15'h0000);
        run(8'h00, 16'h0003, 4'h0, 15'h0000);
        run(8'h10, 16'h0004, 4'h1, 15'h0080);
        run(8'h50, 16'h0004, 4'h1, 15'h0000);
        run(8'h50, 16'h0004, 4'h0, 15'h0080);
        run(8'h10, 16'h0005, 4'h1, 15'h0060);
        run(8'h10, 16'h0006, 4'h1, 15'h0010);
        run(8'h10, 16'h0006, 4'h0, 15'h0000);
        run(8'h10, 16'h0007, 4'h1, 15'h0008);
        run(8'h30, 16'h0007, 4'h1, 15'h0000);
        run(8'h10, 16'h0008, 4'h1, 15'h0004);
        run(8'h10, 16'h0900, 4'h4, 15'h0002);
        run(8'h10, 16'h0900, 4'h0, 15'h0000);
        run(8'h10, 16'h000A, 4'h1, 15'h0001);
        run(8'h11, 16'h0001, 4'h1, 15'h0000);
        run(8'h11, 16'h0010, 4'h2, 15'h6000);
        run(8'h10, 16'h0000, 4'hF, 15'h0000);
        run(8'h10, 16'h0011, 4'h2, 15'h0000);
        rd(eifd_pkg::EIFD_ADDR_FUNCTION, d, r);
        check(d, 32'h0000_0001);
        run(8'h10, 16'h0009, 4'h1, 15'h6000);
        rd(eifd_pkg::EIFD_ADDR_REJECT, d, r);
        check({31'h0, d != 32'h0}, 32'h1);
        run(8'h90, 16'h0900, 4'h4, 15'h0000);
        run(8'h10, 16'h0001, 4'h0, 15'h0000);
        eifd_contact_model_i.bounce(4'h1, DET - 2);
        repeat (LAT) @(posedge aclk);
        check({17'h0, cmd}, 32'h0000_0000);
        eifd_contact_model_i.drive(4'h1);
        repeat (LAT) @(posedge aclk);
        check({16'h0, cmd, lop[0]}, 32'h0000_C000);
        repeat (LOG) @(posedge aclk);
        check({28'h0, lop}, 32'h0000_0001);
        rd(eifd_pkg::EIFD_ADDR_INPUTS, d, r);
        check(d, 32'h0000_0011);
        rd(eifd_pkg::EIFD_ADDR_COMMANDS, d, r);
        check(d, 32'h0000_6000);
        report_and_stop();
    end
endmodule
bind eifd_event_input_function_decoder eifd_properties #(.DETECT_CYCLES(DETECT_CYCLES), .LOGIC_CYCLES(LOGIC_CYCLES)) props_i (
    .aclk(aclk), .aresetn(aresetn), .event_in(event_in), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cmd(cmd), .logic_op_state(logic_op_state));
